// ==== sbcst_pkg.sv ====
// constants for the bus and wake status bank
package sbcst_pkg;
	localparam int REG_W = 8;
	localparam int ADDR_W = 7;
	localparam int FRAME_BITS = 16;
	localparam logic [6:0] ADDR_DEV = 7'h43;
	localparam logic [6:0] ADDR_BUS = 7'h44;
	localparam logic [6:0] ADDR_WAKE = 7'h46;
	localparam logic [7:0] RST_VAL = 8'h00;
	localparam int HIST_HI = 7;
	localparam int WD_HI = 3;
	localparam int SPIF_BIT = 1;
	localparam int FAIL_BIT = 0;
	localparam int LIN_HI = 6;
	localparam int CAN_TIMEOUT_FLAG_BIT = 4;
	localparam int SELECTIVE_WAKE_SYSTEM_ERROR_BIT = 3;
	localparam int CAN_HI = 2;
	localparam int UV_BIT = 0;
	localparam logic [1:0] HIST_CLR = 2'h0;
	localparam logic [1:0] HIST_FAIL = 2'h1;
	localparam logic [1:0] HIST_SLEEP = 2'h2;
	localparam logic [1:0] CODE_NONE = 2'h0;
	localparam logic [1:0] CODE_TSD = 2'h1;
	localparam logic [1:0] CODE_TXD = 2'h2;
	localparam logic [1:0] CODE_BUS = 2'h3;
	localparam logic [1:0] WD_MAX = 2'h3;
	localparam logic [5:0] SWK_ERR_MAX = 6'h20;
	localparam int CLK_MHZ = 100;
	localparam int DOM_TO_MS = 20;
	localparam int DOM_TO_CYC = DOM_TO_MS * CLK_MHZ * 1000;
	localparam int TXEN_TIME_NS = 1000;
	localparam int TXEN_CYC = (TXEN_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int INT_PULSE_NS = 2000;
	localparam int INT_CYC = INT_PULSE_NS * CLK_MHZ / 1000;
endpackage

// ==== sbcst_spi_port.sv ====
// 16-bit serial control port framing
`timescale 1ns/1ns
module sbcst_spi_port (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic spi_clk,
	input wire logic spi_cs_n,
	input wire logic spi_mosi,
	input wire logic [sbcst_pkg::REG_W-1:0] rd_data,
	output logic [sbcst_pkg::ADDR_W-1:0] addr_ff,
	output logic clr_cmd_ff,
	output logic bad_cmd_ff,
	output logic spi_miso,
	output logic spi_miso_oe_n
);
	import sbcst_pkg::*;
	logic [2:0] s1_ff, s2_ff, s3_ff;
	logic [4:0] cnt_ff;
	logic [7:0] rx_ff, tx_ff;
	logic clrbit_ff, ld_ff, ld2_ff;
	logic sck_rise, sck_fall, cs_act, cs_end;
	////////////////////////////////////////////////////////////////
	// pin synchronisers, order clk, cs_n, mosi
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s1_ff <= 3'h2;
			s2_ff <= 3'h2;
			s3_ff <= 3'h2;
		end else begin
			s1_ff <= {spi_clk, spi_cs_n, spi_mosi};
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end
	assign sck_rise = s2_ff[2] & ~s3_ff[2];
	assign sck_fall = ~s2_ff[2] & s3_ff[2];
	assign cs_act = ~s2_ff[1];
	assign cs_end = s2_ff[1] & ~s3_ff[1];
	assign spi_miso_oe_n = s2_ff[1];
	assign spi_miso = tx_ff[7];
	////////////////////////////////////////////////////////////////
	// bit count and command byte
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= 5'h00;
			rx_ff <= 8'h00;
			ld_ff <= 1'b0;
		end else begin
			ld_ff <= cs_act && sck_rise && cnt_ff == 5'h07;
			if (!cs_act) begin
				cnt_ff <= 5'h00;
			end else if (sck_rise && cnt_ff != 5'(FRAME_BITS + 1)) begin
				cnt_ff <= cnt_ff + 5'h01;
			end
			if (cs_act && sck_rise && cnt_ff < 5'h08) begin
				rx_ff <= {rx_ff[6:0], s2_ff[0]};
			end
		end
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			addr_ff <= 7'h00;
			clrbit_ff <= 1'b0;
			ld2_ff <= 1'b0;
		end else begin
			ld2_ff <= ld_ff;
			if (ld_ff) begin
				addr_ff <= rx_ff[6:0];
				clrbit_ff <= rx_ff[7];
			end
		end
	end
	////////////////////////////////////////////////////////////////
	// read data out, end of frame check
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tx_ff <= 8'h00;
			clr_cmd_ff <= 1'b0;
			bad_cmd_ff <= 1'b0;
		end else begin
			if (ld2_ff) begin
				tx_ff <= rd_data;
			end else if (cs_end) begin
				tx_ff <= 8'h00;
			end else if (sck_fall && cnt_ff > 5'h08) begin
				tx_ff <= {tx_ff[6:0], 1'b0};
			end
			clr_cmd_ff <= cs_end && cnt_ff == 5'(FRAME_BITS) && clrbit_ff;
			bad_cmd_ff <= cs_end && cnt_ff != 5'(FRAME_BITS);
		end
	end
endmodule // sbcst_spi_port

// ==== sbcst_status_bank.sv ====
// device history, bus fault and wake source status bank
`timescale 1ns/1ns
module sbcst_status_bank #(
	parameter int DOM_CYC = sbcst_pkg::DOM_TO_CYC,
	parameter int TXEN_CYC = sbcst_pkg::TXEN_CYC,
	parameter int INT_CYC = sbcst_pkg::INT_CYC
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic soft_rst,
	input wire logic spi_clk,
	input wire logic spi_cs_n,
	input wire logic spi_mosi,
	output logic spi_miso,
	output logic spi_miso_oe_n,
	input wire logic restart_fail,
	input wire logic failsafe_wake,
	input wire logic sleep_req,
	input wire logic in_stop,
	input wire logic wake_src_on,
	input wire logic wd_ok,
	input wire logic watchdog_miss_count,
	input wire logic wd_stop,
	input wire logic wd_stop_by_fail,
	input wire logic cfg_sel,
	input wire logic cfg_no_pullup,
	input wire logic fail_req,
	input wire logic fail_release,
	output logic fail_output_pin,
	output logic restart_req,
	input wire logic [1:0] txd_pin,
	input wire logic [1:0] bus_dom,
	input wire logic [1:0] tsd,
	input wire logic [1:0] supply_uv,
	input wire logic [1:0] trx_active,
	input wire logic [1:0] can_mode,
	output logic [1:0] tx_enable,
	input wire logic selective_wake,
	input wire logic can_silence_indication,
	input wire logic can_timeout_irq_mask,
	input wire logic in_normal_or_stop,
	output logic int_n,
	input wire logic swk_cfg_err,
	input wire logic [5:0] swk_err_cnt,
	input wire logic [5:0] wake_evt
);
	import sbcst_pkg::*;
	localparam int DW = $clog2(DOM_CYC + 1);
	localparam int EW = $clog2(TXEN_CYC + 1);
	localparam int IW = $clog2(INT_CYC + 1);
	// interrupt pulse must last at least two cycles for the falling edge lock
	if (DOM_CYC < 1 || TXEN_CYC < 1 || INT_CYC < 2) begin : g_chk
		$error("timing counts too small");
	end
	logic [6:0] addr;
	logic clr_cmd, bad_cmd, clr_dev, clr_bus, clr_wake;
	logic [7:0] dev_reg, bus_reg, wake_reg, rd_data;
	logic [1:0] hist_ff, wd_cnt_ff;
	logic wd_frz_ff, spif_ff, fail_ff, fo_ff, rst_req_ff;
	logic fo_set;
	logic [1:0] code_ff [0:1];
	logic [1:0] cause, uv_on;
	logic uv_ff, can_timeout_flag_ff, lock_ff, selective_wake_system_error_ff, sil_ff, int_n_ff, int_n_d_ff;
	logic to_rise, irq_go;
	logic [IW-1:0] int_cnt_ff;
	logic [5:0] wake_ff;
	logic [1:0] s1_ff, txd_s;
	////////////////////////////////////////////////////////////////
	// serial port and register read
	sbcst_spi_port u_spi (
		.mclk(mclk),
		.rst_n(rst_n),
		.spi_clk(spi_clk),
		.spi_cs_n(spi_cs_n),
		.spi_mosi(spi_mosi),
		.rd_data(rd_data),
		.addr_ff(addr),
		.clr_cmd_ff(clr_cmd),
		.bad_cmd_ff(bad_cmd),
		.spi_miso(spi_miso),
		.spi_miso_oe_n(spi_miso_oe_n)
	);
	function automatic logic [7:0] read_mux(input logic [6:0] a, input logic [7:0] d,
		input logic [7:0] b, input logic [7:0] w);
		if (a == ADDR_DEV) begin
			return d;
		end else if (a == ADDR_BUS) begin
			return b;
		end else if (a == ADDR_WAKE) begin
			return w;
		end else begin
			return RST_VAL;
		end
	endfunction
	assign dev_reg = {hist_ff, 2'b00, wd_cnt_ff, spif_ff, fail_ff};
	assign bus_reg = {1'b0, code_ff[0], can_timeout_flag_ff, selective_wake_system_error_ff, code_ff[1], uv_ff};
	assign wake_reg = {1'b0, wake_ff[5:3], 1'b0, wake_ff[2:0]};
	assign rd_data = read_mux(addr, dev_reg, bus_reg, wake_reg);
	assign clr_dev = clr_cmd && addr == ADDR_DEV;
	assign clr_bus = clr_cmd && addr == ADDR_BUS;
	assign clr_wake = clr_cmd && addr == ADDR_WAKE;
	////////////////////////////////////////////////////////////////
	// restart history
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			hist_ff <= HIST_CLR;
		end else if (soft_rst) begin
			hist_ff <= HIST_CLR;
		end else if (restart_fail || failsafe_wake) begin
			hist_ff <= HIST_FAIL;
		end else if (sleep_req) begin
			hist_ff <= (in_stop || !wake_src_on) ? HIST_FAIL : HIST_SLEEP;
		end else if (clr_dev) begin
			hist_ff <= HIST_CLR;
		end
	end
	////////////////////////////////////////////////////////////////
	// watchdog miss count and fail output
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wd_cnt_ff <= 2'h0;
			wd_frz_ff <= 1'b0;
		end else if (soft_rst || wd_ok) begin
			wd_cnt_ff <= 2'h0;
			wd_frz_ff <= 1'b0;
		end else if (wd_stop && !wd_stop_by_fail) begin
			wd_cnt_ff <= 2'h0;
		end else if (watchdog_miss_count) begin
			wd_frz_ff <= cfg_no_pullup;
			if (!wd_frz_ff && wd_cnt_ff != WD_MAX) begin
				wd_cnt_ff <= wd_cnt_ff + 2'h1;
			end
		end
	end
	assign fo_set = fail_req || (watchdog_miss_count && !(cfg_sel == 1'b0 && wd_cnt_ff == 2'h0));
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			fo_ff <= 1'b0;
			fail_ff <= 1'b0;
			spif_ff <= 1'b0;
			rst_req_ff <= 1'b0;
		end else if (soft_rst) begin
			fo_ff <= 1'b0;
			fail_ff <= 1'b0;
			spif_ff <= 1'b0;
			rst_req_ff <= 1'b0;
		end else begin
			rst_req_ff <= watchdog_miss_count;
			if (fo_set) begin
				fo_ff <= 1'b1;
			end else if (fail_release) begin
				fo_ff <= 1'b0;
			end
			if (fo_set) begin
				fail_ff <= 1'b1;
			end else if (clr_dev) begin
				fail_ff <= 1'b0;
			end
			if (bad_cmd) begin
				spif_ff <= 1'b1;
			end else if (clr_dev) begin
				spif_ff <= 1'b0;
			end
		end
	end
	assign fail_output_pin = fo_ff;
	assign restart_req = rst_req_ff;
	////////////////////////////////////////////////////////////////
	// transceiver faults, index 0 lin, 1 can
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s1_ff <= 2'h3;
			txd_s <= 2'h3;
		end else begin
			s1_ff <= txd_pin;
			txd_s <= s1_ff;
		end
	end
	// can monitor only in mode bit 1
	assign uv_on = {supply_uv[1] & can_mode[1], supply_uv[0]};
	for (genvar i = 0; i < 2; i++) begin : g_trx
		logic [DW-1:0] txc_ff, busc_ff;
		logic [EW-1:0] hic_ff;
		logic txto, busto, rec_ff, ten_ff, tsd_d_ff, txto_d_ff, busto_d_ff;
		// txd timeout ends on high or inactive
		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				txc_ff <= '0;
			end else if (!trx_active[i] || txd_s[i]) begin
				txc_ff <= '0;
			end else if (txc_ff != DW'(DOM_CYC)) begin
				txc_ff <= txc_ff + DW'(1);
			end
		end
		// bus timeout ends on recessive or inactive
		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				busc_ff <= '0;
			end else if (!trx_active[i] || !bus_dom[i]) begin
				busc_ff <= '0;
			end else if (busc_ff != DW'(DOM_CYC)) begin
				busc_ff <= busc_ff + DW'(1);
			end
		end
		assign txto = txc_ff == DW'(DOM_CYC);
		assign busto = busc_ff == DW'(DOM_CYC);
		assign cause[i] = tsd[i] | txto | busto | uv_on[i];
		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				hic_ff <= '0;
				rec_ff <= 1'b0;
				ten_ff <= 1'b0;
			end else begin
				hic_ff <= !txd_s[i] ? '0 : (hic_ff != EW'(TXEN_CYC) ? hic_ff + EW'(1) : hic_ff);
				if (cause[i]) begin
					rec_ff <= 1'b1;
				end else if (hic_ff == EW'(TXEN_CYC)) begin
					rec_ff <= 1'b0;
				end
				ten_ff <= trx_active[i] && !cause[i] && !rec_ff;
			end
		end
		assign tx_enable[i] = ten_ff;
		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				code_ff[i] <= CODE_NONE;
				tsd_d_ff <= 1'b0;
				txto_d_ff <= 1'b0;
				busto_d_ff <= 1'b0;
			end else begin
				tsd_d_ff <= tsd[i];
				txto_d_ff <= txto;
				busto_d_ff <= busto;
				if (soft_rst) begin
					code_ff[i] <= CODE_NONE;
				end else if (tsd[i] && !tsd_d_ff) begin
					code_ff[i] <= CODE_TSD;
				end else if (txto && !txto_d_ff) begin
					code_ff[i] <= CODE_TXD;
				end else if (busto && !busto_d_ff) begin
					code_ff[i] <= CODE_BUS;
				end else if (clr_bus) begin
					code_ff[i] <= CODE_NONE;
				end
			end
		end
	end
	////////////////////////////////////////////////////////////////
	// can supply, timeout, system error, interrupt
	assign to_rise = selective_wake && can_silence_indication && !sil_ff;
	assign irq_go = to_rise && can_timeout_irq_mask && in_normal_or_stop;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			uv_ff <= 1'b0;
			can_timeout_flag_ff <= 1'b0;
			lock_ff <= 1'b0;
			selective_wake_system_error_ff <= 1'b0;
			sil_ff <= 1'b0;
		end else if (soft_rst) begin
			uv_ff <= 1'b0;
			can_timeout_flag_ff <= 1'b0;
			lock_ff <= 1'b0;
			selective_wake_system_error_ff <= 1'b0;
			sil_ff <= 1'b0;
		end else begin
			sil_ff <= can_silence_indication;
			if (uv_on[1]) begin
				uv_ff <= 1'b1;
			end else if (clr_bus) begin
				uv_ff <= 1'b0;
			end
			if (to_rise) begin
				can_timeout_flag_ff <= 1'b1;
			end else if (clr_bus && !lock_ff) begin
				can_timeout_flag_ff <= 1'b0;
			end
			if (irq_go && int_n_ff) begin
				lock_ff <= 1'b1;
			end else if (int_n_d_ff && !int_n_ff) begin
				lock_ff <= 1'b0;
			end
			if (selective_wake && (swk_cfg_err || swk_err_cnt > SWK_ERR_MAX)) begin
				selective_wake_system_error_ff <= 1'b1;
			end else if (clr_bus) begin
				selective_wake_system_error_ff <= 1'b0;
			end
		end
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			int_cnt_ff <= '0;
			int_n_ff <= 1'b1;
			int_n_d_ff <= 1'b1;
		end else begin
			int_n_d_ff <= int_n_ff;
			if (irq_go && int_n_ff) begin
				int_cnt_ff <= IW'(INT_CYC);
				int_n_ff <= 1'b0;
			end else if (int_cnt_ff > IW'(1)) begin
				int_cnt_ff <= int_cnt_ff - IW'(1);
			end else begin
				int_cnt_ff <= '0;
				int_n_ff <= 1'b1;
			end
		end
	end
	assign int_n = int_n_ff;
	////////////////////////////////////////////////////////////////
	// wake source flags
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wake_ff <= 6'h00;
		end else if (soft_rst) begin
			wake_ff <= 6'h00;
		end else begin
			wake_ff <= wake_evt | (clr_wake ? 6'h00 : wake_ff);
		end
	end
	////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	hist_fail_a: assert property (sleep_req && in_stop && !soft_rst && !restart_fail
		|=> hist_ff == HIST_FAIL) else $error("illegal sleep not recorded");
	hist_sleep_a: assert property (sleep_req && !in_stop && wake_src_on && !soft_rst
		&& !restart_fail && !failsafe_wake |=> hist_ff == HIST_SLEEP) else $error("sleep code");
	wd_clear_a: assert property (wd_ok |=> wd_cnt_ff == 2'h0) else $error("count kept");
	wd_stop_a: assert property (wd_stop && !wd_stop_by_fail && !watchdog_miss_count
		|=> wd_cnt_ff == 2'h0) else $error("stop did not clear");
	wd_frz_a: assert property (wd_frz_ff && watchdog_miss_count && !wd_ok && !soft_rst && !wd_stop
		|=> $stable(wd_cnt_ff)) else $error("frozen count moved");
	first_fail_a: assert property (watchdog_miss_count && !cfg_sel && wd_cnt_ff == 2'h0 && !fail_req
		&& !fo_ff |=> !fail_output_pin) else $error("first failure drove fail output");
	spi_fail_a: assert property (bad_cmd && !soft_rst |=> dev_reg[SPIF_BIT])
		else $error("serial fail not flagged");
	failure_a: assert property ($rose(fail_output_pin) |-> fail_ff)
		else $error("failure flag missing");
	can_uv_a: assert property (supply_uv[1] && can_mode[1] && !soft_rst
		|=> uv_ff ##1 !tx_enable[1]) else $error("can supply low ignored");
	can_timeout_flag_a: assert property (to_rise && !soft_rst |=> can_timeout_flag_ff) else $error("no timeout");
	int_a: assert property (irq_go && int_n_ff |=> !int_n [*2])
		else $error("no interrupt pulse");
	lock_a: assert property (lock_ff && clr_bus && can_timeout_flag_ff && !soft_rst
		|=> can_timeout_flag_ff) else $error("locked timeout cleared");
	selective_wake_system_error_a: assert property (!selective_wake && !clr_bus && !soft_rst
		|=> $stable(selective_wake_system_error_ff)) else $error("system error moved while disabled");
	wake_a: assert property (wake_evt[5] && !soft_rst |=> wake_reg[6])
		else $error("lin wake lost");
	cov_sleep_c: cover property (sleep_req ##1 hist_ff == HIST_SLEEP);
	cov_irq_c: cover property (irq_go ##1 !int_n);
	cov_rec_c: cover property (cause[0] ##[1:300] tx_enable[0]);
endmodule // sbcst_status_bank

// ==== sbcst_host.sv ====
// host controller model driving the 16-bit serial control port
`timescale 1ns/1ns
module sbcst_host (
	input wire logic mclk,
	output logic spi_clk,
	output logic spi_cs_n,
	output logic spi_mosi,
	input wire logic spi_miso,
	input wire logic spi_miso_oe_n
);
	initial begin
		spi_clk = 1'b0;
		spi_cs_n = 1'b1;
		spi_mosi = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// framed access, clear bit first
	task automatic frame(input logic c, input logic [6:0] a, input int nb, output logic [7:0] d);
		logic [15:0] w;
		w = {c, a, 8'h00};
		d = 8'h00;
		@(posedge mclk) spi_cs_n <= 1'b0;
		for (int i = 0; i < nb; i++) begin
			spi_mosi <= w[15 - i];
			repeat (8) @(posedge mclk);
			spi_clk <= 1'b1;
			if (i >= 8) begin
				d = {d[6:0], (spi_miso_oe_n === 1'b0) ? spi_miso : 1'bx};
			end
			repeat (8) @(posedge mclk);
			spi_clk <= 1'b0;
		end
		repeat (6) @(posedge mclk);
		spi_cs_n <= 1'b1;
		spi_mosi <= ~spi_mosi;
		repeat (8) @(posedge mclk);
	endtask
endmodule // sbcst_host

// ==== tb.sv ====
// self-checking testbench for the bus and wake status bank
`timescale 1ns/1ns
module tb;
	import sbcst_pkg::*;
	logic mclk = 0, rst_n = 0, soft_rst = 0;
	logic spi_clk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe_n;
	logic restart_fail = 0, failsafe_wake = 0, sleep_req = 0, in_stop = 0, wake_src_on = 1;
	logic wd_ok = 0, watchdog_miss_count = 0, wd_stop = 0, wd_stop_by_fail = 0, cfg_sel = 0;
	logic cfg_no_pullup = 0, fail_req = 0, fail_release = 0, fail_output_pin, restart_req;
	logic [1:0] txd_pin = 2'h3, bus_dom = 2'h0, tsd = 2'h0, supply_uv = 2'h0;
	logic [1:0] trx_active = 2'h3, can_mode = 2'h2, tx_enable;
	logic selective_wake = 0, can_silence_indication = 0, can_timeout_irq_mask = 1;
	logic in_normal_or_stop = 1, int_n, swk_cfg_err = 0;
	logic [5:0] swk_err_cnt = 6'h00, wake_evt = 6'h00;
	logic [7:0] d, e;
	logic hit;
	int n_fail = 0, cmp_count = 0, m = 0;
	integer seed = 32'h864b9912;
	always #5 mclk = ~mclk;
	sbcst_status_bank #(.DOM_CYC(20), .TXEN_CYC(3), .INT_CYC(4)) uut (.mclk, .rst_n, .soft_rst,
		.spi_clk, .spi_cs_n, .spi_mosi, .spi_miso, .spi_miso_oe_n, .restart_fail,
		.failsafe_wake, .sleep_req, .in_stop, .wake_src_on, .wd_ok, .watchdog_miss_count, .wd_stop,
		.wd_stop_by_fail, .cfg_sel, .cfg_no_pullup, .fail_req, .fail_release, .fail_output_pin,
		.restart_req, .txd_pin, .bus_dom, .tsd, .supply_uv, .trx_active, .can_mode, .tx_enable,
		.selective_wake, .can_silence_indication, .can_timeout_irq_mask, .in_normal_or_stop,
		.int_n, .swk_cfg_err, .swk_err_cnt, .wake_evt);
	sbcst_host host (.mclk, .spi_clk, .spi_cs_n, .spi_mosi, .spi_miso, .spi_miso_oe_n);
	////////////////////////////////////////////////////////////////////////////////
	task automatic tk(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] x);
		cmp_count++;
		if (g !== x) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	task automatic rd(input logic c, input logic [6:0] a, input logic [7:0] k, input logic [7:0] x);
		host.frame(c, a, 16, d);
		chk(d & k, x);
	endtask
	task automatic pw(input int n);
		repeat (n) begin
			@(posedge mclk) watchdog_miss_count <= 1'b1;
			@(posedge mclk) watchdog_miss_count <= 1'b0;
		end
	endtask
	task automatic fin(input string s);
		$display("test %s done", s);
	endtask
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		tk(60000);
		n_fail++;
		complete_run();
	end
	initial begin
		tk(6);
		rst_n <= 1'b1;
		tk(20);
		rd(0, ADDR_DEV, 8'hff, RST_VAL);
		rd(0, ADDR_BUS, 8'hff, RST_VAL);
		rd(0, ADDR_WAKE, 8'hff, RST_VAL);
		rd(0, 7'h45, 8'hff, 8'h00);
		chk({6'h0, tx_enable}, 8'h03);
		fin("reset");
		repeat (4) begin
			e = 8'($random(seed));
			@(posedge mclk) wake_evt <= e[5:0];
			@(posedge mclk) wake_evt <= 6'h00;
			m = m | {1'b0, e[5:3], 1'b0, e[2:0]};
			rd(0, ADDR_WAKE, 8'hff, m[7:0]);
		end
		rd(1, ADDR_WAKE, 8'hff, m[7:0]);
		rd(0, ADDR_WAKE, 8'hff, 8'h00);
		@(posedge mclk) wake_evt <= 6'h3f;
		@(posedge mclk) wake_evt <= 6'h00;
		@(posedge mclk) soft_rst <= 1'b1;
		@(posedge mclk) soft_rst <= 1'b0;
		rd(0, ADDR_WAKE, 8'hff, 8'h00);
		fin("wake");
		for (int k = 0; k < 5; k++) begin
			@(posedge mclk);
			in_stop <= (k == 1);
			wake_src_on <= (k != 2);
			sleep_req <= (k < 3);
			restart_fail <= (k == 3);
			failsafe_wake <= (k == 4);
			@(posedge mclk);
			{sleep_req, restart_fail, failsafe_wake} <= 3'h0;
			rd(1, ADDR_DEV, 8'hc0, k == 0 ? 8'h80 : 8'h40);
		end
		in_stop <= 1'b0;
		wake_src_on <= 1'b1;
		rd(0, ADDR_DEV, 8'hc0, 8'h00);
		fin("history");
		pw(1);
		hit = 1'b0;
		repeat (4) begin
			#1 hit = hit | restart_req;
			@(posedge mclk);
		end
		chk({7'h0, hit}, 8'h01);
		chk({7'h0, fail_output_pin}, 8'h00);
		rd(0, ADDR_DEV, 8'h0f, 8'h04);
		@(posedge mclk) wd_ok <= 1'b1;
		@(posedge mclk) wd_ok <= 1'b0;
		rd(0, ADDR_DEV, 8'h0c, 8'h00);
		cfg_sel <= 1'b1;
		pw(4);
		rd(0, ADDR_DEV, 8'h0c, 8'h0c);
		wd_stop_by_fail <= 1'b1;
		@(posedge mclk) wd_stop <= 1'b1;
		@(posedge mclk) wd_stop <= 1'b0;
		rd(0, ADDR_DEV, 8'h0c, 8'h0c);
		wd_stop_by_fail <= 1'b0;
		@(posedge mclk) wd_stop <= 1'b1;
		@(posedge mclk) wd_stop <= 1'b0;
		rd(0, ADDR_DEV, 8'h0c, 8'h00);
		cfg_no_pullup <= 1'b1;
		pw(2);
		rd(0, ADDR_DEV, 8'h0c, 8'h04);
		@(posedge mclk) wd_ok <= 1'b1;
		@(posedge mclk) wd_ok <= 1'b0;
		rd(0, ADDR_DEV, 8'h0c, 8'h00);
		fin("watchdog");
		@(posedge mclk) fail_release <= 1'b1;
		@(posedge mclk) fail_release <= 1'b0;
		rd(1, ADDR_DEV, 8'hff, 8'h01);
		@(posedge mclk) fail_req <= 1'b1;
		@(posedge mclk) fail_req <= 1'b0;
		tk(2);
		chk({7'h0, fail_output_pin}, 8'h01);
		@(posedge mclk) fail_release <= 1'b1;
		@(posedge mclk) fail_release <= 1'b0;
		tk(2);
		chk({7'h0, fail_output_pin}, 8'h00);
		host.frame(0, ADDR_DEV, 12, d);
		rd(0, ADDR_DEV, 8'h03, 8'h03);
		rd(1, ADDR_DEV, 8'h03, 8'h03);
		rd(0, ADDR_DEV, 8'h03, 8'h00);
		fin("fail");
		tsd <= 2'h3;
		tk(4);
		chk({6'h0, tx_enable}, 8'h00);
		tsd <= 2'h0;
		tk(14);
		chk({6'h0, tx_enable}, 8'h03);
		rd(1, ADDR_BUS, 8'hff, 8'h22);
		txd_pin <= 2'h0;
		tk(30);
		chk({6'h0, tx_enable}, 8'h00);
		rd(1, ADDR_BUS, 8'hff, 8'h44);
		txd_pin <= 2'h3;
		tk(3);
		chk({6'h0, tx_enable}, 8'h00);
		tk(12);
		chk({6'h0, tx_enable}, 8'h03);
		bus_dom <= 2'h3;
		tk(30);
		rd(1, ADDR_BUS, 8'hff, 8'h66);
		bus_dom <= 2'h0;
		tk(14);
		chk({6'h0, tx_enable}, 8'h03);
		supply_uv <= 2'h2;
		tk(4);
		chk({7'h0, tx_enable[1]}, 8'h00);
		supply_uv <= 2'h0;
		tk(14);
		chk({6'h0, tx_enable}, 8'h03);
		rd(1, ADDR_BUS, 8'hff, 8'h01);
		can_mode <= 2'h0;
		supply_uv <= 2'h2;
		tk(6);
		supply_uv <= 2'h0;
		rd(0, ADDR_BUS, 8'hff, 8'h00);
		can_mode <= 2'h2;
		fin("bus");
		selective_wake <= 1'b1;
		@(posedge mclk) can_silence_indication <= 1'b1;
		hit = 1'b0;
		repeat (8) begin
			#1 hit = hit | ~int_n;
			@(posedge mclk);
		end
		chk({7'h0, hit}, 8'h01);
		can_silence_indication <= 1'b0;
		swk_err_cnt <= 6'h21;
		tk(4);
		swk_err_cnt <= 6'h00;
		rd(1, ADDR_BUS, 8'hff, 8'h18);
		tk(4);
		rd(0, ADDR_BUS, 8'hff, 8'h00);
		swk_cfg_err <= 1'b1;
		tk(4);
		swk_cfg_err <= 1'b0;
		rd(1, ADDR_BUS, 8'hff, 8'h08);
		can_timeout_irq_mask <= 1'b0;
		@(posedge mclk) can_silence_indication <= 1'b1;
		hit = 1'b0;
		repeat (8) begin
			#1 hit = hit | ~int_n;
			@(posedge mclk);
		end
		chk({7'h0, hit}, 8'h00);
		can_silence_indication <= 1'b0;
		can_timeout_irq_mask <= 1'b1;
		rd(1, ADDR_BUS, 8'hff, 8'h10);
		selective_wake <= 1'b0;
		swk_cfg_err <= 1'b1;
		tk(4);
		swk_cfg_err <= 1'b0;
		rd(0, ADDR_BUS, 8'hff, 8'h00);
		fin("selective");
		complete_run();
	end
endmodule // tb
